// ==== core/ascs_sign_corrector.sv ====
// Notes on behaviour
// [RL1] Signed, equal signs: sign of difference
// [RL2] Signed, differing signs: carry out of sign
// [RL3] Unsigned: inverted carry, any carry-in
// [RL4] Bit 0 becomes bit 0 OR sign
// [RL5] Signed, no carry-in, equal signs: reduced difference sign
// [RL6] Sign source ignores the carry-in setting
// [RL7] Result, sign and equal outputs hold their last answer while no request is valid; valid_o drops
`timescale 1ns/1ns

module ascs_sign_corrector
	import ascs_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_b_i,
	// From the adder
	input  wire logic              valid_i,
	input  wire logic              signed_mode_i,
	input  wire logic              carry_forced_i,
	input  wire logic              a_sign_i,
	input  wire logic              b_sign_i,
	input  wire logic [DATA_W-1:0] sum_i,
	input  wire logic              carry_out_i,
	// To the compare logic
	output logic                   valid_o,
	output logic [DATA_W-1:0]      result_o,
	output logic                   true_sign_o,
	output logic                   equal_o
);

	// ============================================================
	// Decoding shared by logic and checks

	// The source depends on mode and operand signs only
	function automatic ascs_src_type pick_source(
		input logic signed_mode,
		input logic a_sign,
		input logic b_sign
	);
		ascs_src_type choice;
		choice = SRC_NOT_CARRY;
		if (signed_mode && (a_sign == b_sign)) begin
			choice = SRC_SUM_SIGN;
		end else if (signed_mode) begin
			choice = SRC_CARRY;
		end
		return choice;
	endfunction

	function automatic logic pick_sign(
		input logic signed_mode,
		input logic a_sign,
		input logic b_sign,
		input logic sum_sign,
		input logic carry
	);
		logic sgn;
		sgn = ~carry;
		case (pick_source(signed_mode, a_sign, b_sign))
			SRC_SUM_SIGN: begin
				sgn = sum_sign;
			end
			SRC_CARRY: begin
				sgn = carry;
			end
			default: begin
				sgn = ~carry;
			end
		endcase
		return sgn;
	endfunction

	// ============================================================
	// Combinational correction
	ascs_src_type      src;
	logic              next_true_sign;
	logic [DATA_W-1:0] next_result;
	logic              next_equal;

	// Carry-in is deliberately not an argument here
	assign src = pick_source(signed_mode_i, a_sign_i, b_sign_i); // RL6

	always_comb begin
		next_true_sign = ~carry_out_i; // RL3
		case (src)
			SRC_SUM_SIGN: begin
				// Also holds for the reduced A - B - 1 form
				next_true_sign = sum_i[SIGN_BIT]; // RL1 RL5
			end
			SRC_CARRY: begin
				// Overflow can flip the sum sign; the carry keeps the true one
				next_true_sign = carry_out_i; // RL2
			end
			default: begin
				next_true_sign = ~carry_out_i; // RL3
			end
		endcase
	end

	// Only A - B = 2**31 would otherwise read as zero
	always_comb begin
		next_result          = sum_i;
		next_result[LSB_BIT] = sum_i[LSB_BIT] | sum_i[SIGN_BIT]; // RL4
	end

	// Without forced carry the adder gives A - B - 1, so equality is all ones
	always_comb begin
		if (carry_forced_i) begin
			next_equal = (sum_i == WORD_ZERO);
		end else begin
			next_equal = (sum_i == WORD_ALL_ONES);
		end
	end

	// ============================================================
	// Output registers
	// One cycle of latency is the price of glitch-free outputs to the compare logic

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			valid_o <= BIT_CLEAR;
		end else begin
			valid_o <= valid_i;
		end
	end

	// Results hold between requests so the consumer may sample late
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			result_o    <= WORD_ZERO;
			true_sign_o <= BIT_CLEAR;
			equal_o     <= BIT_CLEAR;
		end else if (valid_i) begin
			result_o    <= next_result; // RL7
			true_sign_o <= next_true_sign;
			equal_o     <= next_equal;
		end
	end

	// ============================================================
	// Checks
	// Each answer is held against the inputs of the edge that took it;
	// the sum and carry may come from any adder, so only the corrector is judged

	default clocking cb @(posedge clk_i);
	endclocking

	default disable iff (!rst_b_i);

	sequence signed_same_s;
		valid_i && signed_mode_i && (a_sign_i == b_sign_i);
	endsequence

	sequence signed_diff_s;
		valid_i && signed_mode_i && (a_sign_i != b_sign_i);
	endsequence

	sequence unsigned_s;
		valid_i && !signed_mode_i;
	endsequence

	sequence reduced_same_s;
		signed_same_s ##0 !carry_forced_i;
	endsequence

	sequence idle_s;
		!valid_i;
	endsequence

	same_sign_a: assert property ( // RL1
		signed_same_s |=> valid_o && (true_sign_o == $past(sum_i[SIGN_BIT]))
	) else $error("signed equal-sign result does not follow sum sign");

	diff_sign_a: assert property ( // RL2
		signed_diff_s |=> valid_o && (true_sign_o == $past(carry_out_i))
	) else $error("signed differing-sign result does not follow carry");

	unsigned_sign_a: assert property ( // RL3
		unsigned_s |=> valid_o && (true_sign_o != $past(carry_out_i))
	) else $error("unsigned result is not the inverted carry");

	lsb_fix_a: assert property ( // RL4
		valid_i |=> (result_o[LSB_BIT] == ($past(sum_i[LSB_BIT]) | $past(sum_i[SIGN_BIT])))
			&& (result_o[SIGN_BIT:1] == $past(sum_i[SIGN_BIT:1]))
	) else $error("corrected result bits do not match the sum");

	never_zero_a: assert property ( // RL4
		(valid_i && sum_i[SIGN_BIT]) |=> (result_o != WORD_ZERO)
	) else $error("negative difference reads as zero");

	reduced_diff_a: assert property ( // RL5
		reduced_same_s |=> (true_sign_o == $past(sum_i[SIGN_BIT]))
	) else $error("reduced difference sign not used");

	carry_indep_a: assert property ( // RL6
		valid_i |=> true_sign_o == pick_sign($past(signed_mode_i), $past(a_sign_i),
			$past(b_sign_i), $past(sum_i[SIGN_BIT]), $past(carry_out_i))
	) else $error("sign source depends on more than mode and signs");

	sign_table_a: assert property ( // RL6
		valid_i |=> true_sign_o == ($past(signed_mode_i)
			? (($past(a_sign_i) == $past(b_sign_i)) ? $past(sum_i[SIGN_BIT])
				: $past(carry_out_i))
			: !$past(carry_out_i))
	) else $error("sign choice differs from the mode and sign table");

	hold_idle_a: assert property ( // RL7
		idle_s |=> !valid_o && $stable(result_o) && $stable(true_sign_o)
			&& $stable(equal_o)
	) else $error("outputs changed without a request");

	valid_follow_a: assert property (
		valid_i |=> valid_o
	) else $error("request taken without an answer");

	equal_flag_a: assert property (
		valid_i |=> equal_o == ($past(carry_forced_i) ? ($past(sum_i) == WORD_ZERO)
			: ($past(sum_i) == WORD_ALL_ONES))
	) else $error("equal flag does not match the carry-in form");

endmodule

// ==== core/ascs_pkg.sv ====
// ============================================================
// Shared constants for the sign corrector
package ascs_pkg;

	// ============================================================
	// Datapath geometry
	localparam int unsigned DATA_W   = 32;
	localparam int unsigned SIGN_BIT = 31;
	localparam int unsigned LSB_BIT  = 0;

	// ============================================================
	// Reset and reference values
	localparam logic [DATA_W-1:0] WORD_ZERO     = 32'h0000_0000;
	localparam logic [DATA_W-1:0] WORD_ALL_ONES = 32'hffff_ffff;
	localparam logic              BIT_CLEAR     = 1'h0;

	// ============================================================
	// Where the corrected sign is taken from
	typedef enum logic [1:0] {
		SRC_SUM_SIGN,
		SRC_CARRY,
		SRC_NOT_CARRY
	} ascs_src_type;

endpackage

// ==== verif/ascs_adder_model.sv ====
`timescale 1ns/1ns
// ============================================================
// Adder ahead of the corrector
module ascs_adder_model
	import ascs_pkg::*;
(
	// Operands
	input  wire logic [DATA_W-1:0] a_i,
	input  wire logic [DATA_W-1:0] b_i,
	input  wire logic              cin_i,
	// Difference
	output logic [DATA_W-1:0]      sum_o,
	output logic                   cout_o
);
	// No forced carry-in leaves A - B - 1
	assign {cout_o, sum_o} = {1'h0, a_i} + {1'h0, ~b_i} + {32'h0, cin_i};
endmodule

// ==== verif/alu_sign_corrector_tb.sv ====
`timescale 1ns/1ns
// ============================================================
// Bench for the sign corrector
module alu_sign_corrector_tb
	import ascs_pkg::*;
;
	logic              clk_i = 1'h0;
	logic              rst_b_i = 1'h0;
	logic              vi = 1'h0;
	logic              sm = 1'h0;
	logic              cin = 1'h0;
	logic [DATA_W-1:0] a = WORD_ZERO;
	logic [DATA_W-1:0] b = WORD_ZERO;
	logic [DATA_W-1:0] sum;
	logic [DATA_W-1:0] res;
	logic              cout;
	logic              vo;
	logic              ts;
	logic              eq;
	int                num_errors = 0;
	int                comparisons = 0;
	int                cycles = 0;
	// Overflow corners and the unrepresentable 2**31 difference
	logic [DATA_W-1:0] va [6] = '{32'h0000_0005, 32'h8000_0000, 32'h7fff_ffff,
		32'h0000_0000, 32'hffff_ffff, 32'h1234_5678};
	logic [DATA_W-1:0] vb [6] = '{32'h0000_0005, 32'h0000_0001, 32'hffff_ffff,
		32'h8000_0000, 32'hffff_fffe, 32'h8765_4321};

	always #4 clk_i = ~clk_i;

	ascs_adder_model adder (.a_i(a), .b_i(b), .cin_i(cin), .sum_o(sum), .cout_o(cout));
	ascs_sign_corrector uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .valid_i(vi),
		.signed_mode_i(sm), .carry_forced_i(cin), .a_sign_i(a[SIGN_BIT]),
		.b_sign_i(b[SIGN_BIT]), .sum_i(sum), .carry_out_i(cout), .valid_o(vo),
		.result_o(res), .true_sign_o(ts), .equal_o(eq));

	task automatic check_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
		input string what);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp, input string what);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask

	task automatic give_verdict();
		if (num_errors == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Back-to-back requests; the sign expected is A < B with forced carry, A <= B without
	task automatic t_sweep(input logic s);
		logic              lt;
		logic [DATA_W-1:0] d;
		for (int c = 1; c >= 0; c--) begin
			for (int i = 0; i < 6; i++) begin
				sm = s;
				cin = c[0];
				a = va[i];
				b = vb[i];
				vi = 1'h1;
				@(negedge clk_i);
				d = va[i] - vb[i] - {31'h0, ~c[0]};
				lt = s ? ($signed(va[i]) < $signed(vb[i])) : (va[i] < vb[i]);
				if (!c[0]) begin
					lt = s ? ($signed(va[i]) <= $signed(vb[i])) : (va[i] <= vb[i]);
				end
				check_bit(vo, 1'h1, "valid");
				check_bit(ts, lt, "sign");
				check_word(res, {d[31:1], d[0] | d[31]}, "result");
				check_bit(eq, va[i] == vb[i], "equal");
			end
		end
	endtask

	// Idle cycle must not disturb the held answer
	task automatic t_hold();
		logic [DATA_W-1:0] r;
		logic              s;
		logic              e;
		r = res;
		s = ts;
		e = eq;
		vi = 1'h0;
		sm = 1'h1;
		cin = 1'h1;
		a = b;
		@(negedge clk_i);
		check_bit(vo, 1'h0, "idle valid");
		check_word(res, r, "held result");
		check_bit(ts, s, "held sign");
		check_bit(eq, e, "held equal");
	endtask

	// Reset in mid-run clears everything; the next request is taken at once
	task automatic t_reset();
		vi = 1'h0;
		rst_b_i = 1'h0;
		@(negedge clk_i);
		check_bit(vo, 1'h0, "valid in reset");
		check_word(res, WORD_ZERO, "result in reset");
		check_bit(ts, 1'h0, "sign in reset");
		check_bit(eq, 1'h0, "equal in reset");
		rst_b_i = 1'h1;
		sm = 1'h1;
		cin = 1'h1;
		a = 32'h0000_0003;
		b = 32'h0000_0007;
		vi = 1'h1;
		@(negedge clk_i);
		check_bit(vo, 1'h1, "valid after reset");
		check_bit(ts, 1'h1, "sign after reset");
		check_word(res, 32'hffff_fffd, "result after reset");
		check_bit(eq, 1'h0, "equal after reset");
		vi = 1'h0;
		@(negedge clk_i);
		check_bit(vo, 1'h0, "valid drop after reset");
	endtask

	initial begin
		repeat (2) @(negedge clk_i);
		rst_b_i = 1'h1;
		t_sweep(1'h1);
		t_sweep(1'h0);
		t_hold();
		t_reset();
		give_verdict();
	end

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 200) begin
			num_errors++;
			give_verdict();
		end
	end
endmodule
